// *** ifc_params.svh ***
// Register offsets, field positions, reset values and masks of the interrupt flag block.
// Assumes byte addressing on a 32-bit APB with one register per aligned word.
`ifndef IFC_PARAMS_SVH
`define IFC_PARAMS_SVH

`define IFC_OFF_TRAP        12'h000
`define IFC_OFF_VEC         12'h004
`define IFC_OFF_FLAG0       12'h008
`define IFC_OFF_FLAG1       12'h00C
`define IFC_OFF_IRQ_STAT    12'h010
`define IFC_OFF_IRQ_MASK    12'h014

`define IFC_RESET_VALUE     16'h0000

`define IFC_TRAP_ADDR_BIT   3
`define IFC_TRAP_STACK_BIT  2
`define IFC_TRAP_OSC_BIT    1
`define IFC_TRAP_MASK       16'h000E

`define IFC_VEC_ALT_BIT     15
`define IFC_VEC_HOLD_BIT    14
`define IFC_VEC_EDGE_MASK   16'h0007
`define IFC_VEC_WR_MASK     16'h8007

`define IFC_FLAG0_MASK      16'h7FFF
`define IFC_FLAG1_MASK      16'hFFDF

`define IFC_STAT_TRAP_BIT   0
`define IFC_STAT_FLAG0_BIT  1
`define IFC_STAT_FLAG1_BIT  2
`define IFC_STAT_MASK       16'h0007

`endif

// *** ifc_pkg.sv ***
// Types shared by the interrupt flag block.
// Assumes the constants header is included alongside.
package ifc_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ifc_apb_req_t;

    typedef struct packed {
        logic        address_fault_trap_flag;
        logic        stack_fault_trap_flag;
        logic        oscillator_fault_trap_flag;
    } ifc_trap_t;

    typedef enum logic [1:0] {
        IFC_ST_IDLE   = 2'b01,
        IFC_ST_ACCESS = 2'b10
    } ifc_state_t;

endpackage : ifc_pkg

// *** ifc_sticky_bank.sv ***
// A bank of sixteen sticky flags with set-over-clear priority.
// Assumes set pulses and software writes are synchronous to pclk.
`timescale 1ns/1ps
module ifc_sticky_bank
    import ifc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic [15:0] impl_mask,
    input  wire logic [15:0] hw_set,
    input  wire logic        sw_we,
    input  wire logic [15:0] sw_data,
    // State
    output logic      [15:0] flags_reg
);

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags_reg[i] <= 1'b0;
                end else if (!impl_mask[i]) begin
                    flags_reg[i] <= 1'b0;
                end else if (hw_set[i]) begin
                    flags_reg[i] <= 1'b1;
                end else if (sw_we) begin
                    flags_reg[i] <= sw_data[i];
                end
            end
        end
    endgenerate

endmodule : ifc_sticky_bank

// *** ifc_flag_regs.sv ***
// Interrupt control and flag registers behind an APB slave.
// Assumes peripherals give one-cycle event pulses synchronous to pclk.
//
// Functional notes
// - Trap register shows address, stack and oscillator trap causes in bits 3..1.
// - Unimplemented bits of all six registers read as zero.
// - Bit 15 of vector control selects alternate vector table; reset zero.
// - Bit 14 of vector control reads one while interrupt hold instruction active.
// - Bits 2..0 pick falling (1) or rising (0) edge for external irqs.
// - Each implemented flag is read/write, resets zero, shows request occurred.
// - Bank 0 bits 14..8: dma1, adc, uart1 tx/rx, spi event/error, timer3.
// - Bank 0 bits 7..0: timer2, cmp2, cap2, dma0, timer1, cmp1, cap1, ext0.
// - Bank 1 bits 15..8: uart2 tx/rx, ext2, timer5, timer4, cmp4, cmp3, dma2.
// - Bank 1: cap8 bit 7, cap7 bit 6, ext1 bit 4, input change bit 3.
// - Bank 1: comparator bit 2, two-wire master bit 1, slave bit 0.
// - Flag bit order follows vector order, matching enable and priority layout.
`timescale 1ns/1ps
`include "ifc_params.svh"
module ifc_flag_regs
    import ifc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core and trap sources
    input  wire ifc_trap_t   trap_event,
    input  wire logic        interrupt_hold_active,
    // Peripheral event pulses, bit positions as in the flag banks
    input  wire logic [15:0] bank0_event,
    input  wire logic [15:0] bank1_event,
    // To vector logic and edge detectors
    output logic             alternate_vector_select,
    output logic      [2:0]  ext_irq_edge_select,
    output logic      [15:0] irq_flags_bank0,
    output logic      [15:0] irq_flags_bank1,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    ifc_apb_req_t req;
    ifc_state_t   state_reg;
    logic [15:0]  trap_reg;
    logic [15:0]  vec_reg;
    logic         hold_reg;
    logic [15:0]  stat_reg;
    logic [15:0]  mask_reg;
    logic [15:0]  flag0_q;
    logic [15:0]  flag1_q;
    logic [15:0]  trap_set;
    logic         wr_en;
    logic         rd_en;
    logic [15:0]  rd_next;
    logic         err_next;
    logic [15:0]  stat_set;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = addr_hit(a, `IFC_OFF_TRAP) || addr_hit(a, `IFC_OFF_VEC)
                  || addr_hit(a, `IFC_OFF_FLAG0) || addr_hit(a, `IFC_OFF_FLAG1)
                  || addr_hit(a, `IFC_OFF_IRQ_STAT) || addr_hit(a, `IFC_OFF_IRQ_MASK);
    endfunction : addr_known

    // A write lands only at the edge that completes the access phase, so a master that
    // drops the transfer before pready is seen leaves every register untouched.
    assign wr_en = req.psel && req.penable && pready && req.pwrite && addr_known(req.paddr);
    // Read data is picked in the setup cycle and registered, so it stands during the
    // access cycle without a combinational path from the address to prdata.
    assign rd_en = req.psel && !req.penable && !req.pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait-free access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IFC_ST_IDLE;
        end else begin
            case (state_reg)
                IFC_ST_IDLE: begin
                    if (req.psel && !req.penable) begin
                        state_reg <= IFC_ST_ACCESS;
                    end
                end
                IFC_ST_ACCESS: begin
                    state_reg <= IFC_ST_IDLE;
                end
                default: begin
                    state_reg <= IFC_ST_IDLE;
                end
            endcase
        end
    end

    // The slave never stretches a transfer: pready answers the setup cycle at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= (state_reg == IFC_ST_IDLE) && req.psel && !req.penable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trap cause capture.
    always_comb begin
        trap_set = 16'h0000;
        trap_set[`IFC_TRAP_ADDR_BIT]  = trap_event.address_fault_trap_flag;
        trap_set[`IFC_TRAP_STACK_BIT] = trap_event.stack_fault_trap_flag;
        trap_set[`IFC_TRAP_OSC_BIT]   = trap_event.oscillator_fault_trap_flag;
    end

    // A trap that fires in the cycle of a software write still lands: set wins.
    // Unimplemented trap bits zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_reg <= `IFC_RESET_VALUE;
        end else if (wr_en && addr_hit(req.paddr, `IFC_OFF_TRAP)) begin
            trap_reg <= (req.pwdata[15:0] | trap_set) & `IFC_TRAP_MASK;
        end else begin
            trap_reg <= (trap_reg | trap_set) & `IFC_TRAP_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Vector table select and edge polarity, writable bits only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec_reg <= `IFC_RESET_VALUE;
        end else if (wr_en && addr_hit(req.paddr, `IFC_OFF_VEC)) begin
            vec_reg <= req.pwdata[15:0] & `IFC_VEC_WR_MASK;
        end
    end

    // The hold level is registered once, so a read shows the core's state of the
    // cycle before the setup edge; software cannot resolve a difference that small.
    // Hold status tracks the core.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 1'b0;
        end else begin
            hold_reg <= interrupt_hold_active;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alternate_vector_select <= 1'b0;
        end else begin
            alternate_vector_select <= vec_reg[`IFC_VEC_ALT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_edge_select <= 3'b000;
        end else begin
            ext_irq_edge_select <= vec_reg[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Unimplemented positions are tied off inside each bank through its mask.
    // Bank 0 flags, bit order follows vectors.
    ifc_sticky_bank u_bank0 (
        .pclk      (pclk),
        .presetn   (presetn),
        .impl_mask (`IFC_FLAG0_MASK),
        .hw_set    (bank0_event),
        .sw_we     (wr_en && addr_hit(req.paddr, `IFC_OFF_FLAG0)),
        .sw_data   (req.pwdata[15:0]),
        .flags_reg (flag0_q)
    );

    // Bank 1 flags, bit 5 absent.
    ifc_sticky_bank u_bank1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .impl_mask (`IFC_FLAG1_MASK),
        .hw_set    (bank1_event),
        .sw_we     (wr_en && addr_hit(req.paddr, `IFC_OFF_FLAG1)),
        .sw_data   (req.pwdata[15:0]),
        .flags_reg (flag1_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags_bank0 <= `IFC_RESET_VALUE;
        end else begin
            irq_flags_bank0 <= flag0_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags_bank1 <= `IFC_RESET_VALUE;
        end else begin
            irq_flags_bank1 <= flag1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Summary interrupt: sticky events, write one to clear, set wins.
    // Each status bit gathers one source group and never sees unimplemented bits.
    always_comb begin
        stat_set = 16'h0000;
        stat_set[`IFC_STAT_TRAP_BIT]  = |trap_set;
        stat_set[`IFC_STAT_FLAG0_BIT] = |(bank0_event & `IFC_FLAG0_MASK);
        stat_set[`IFC_STAT_FLAG1_BIT] = |(bank1_event & `IFC_FLAG1_MASK);
    end

    // An event in the cycle of a write-one-to-clear keeps its status bit set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= `IFC_RESET_VALUE;
        end else if (wr_en && addr_hit(req.paddr, `IFC_OFF_IRQ_STAT)) begin
            stat_reg <= ((stat_reg & ~req.pwdata[15:0]) | stat_set) & `IFC_STAT_MASK;
        end else begin
            stat_reg <= (stat_reg | stat_set) & `IFC_STAT_MASK;
        end
    end

    // Mask bits gate only the summary output, never the status bits themselves.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= `IFC_RESET_VALUE;
        end else if (wr_en && addr_hit(req.paddr, `IFC_OFF_IRQ_MASK)) begin
            mask_reg <= req.pwdata[15:0] & `IFC_STAT_MASK;
        end
    end

    // The output lags the status by one cycle so that it comes from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux, reserved bits zero.
    always_comb begin
        rd_next  = 16'h0000;
        err_next = 1'b0;
        case (req.paddr)
            `IFC_OFF_TRAP:     rd_next = trap_reg & `IFC_TRAP_MASK;
            `IFC_OFF_VEC: begin
                rd_next = vec_reg & `IFC_VEC_WR_MASK;
                rd_next[`IFC_VEC_HOLD_BIT] = hold_reg;
            end
            `IFC_OFF_FLAG0:    rd_next = flag0_q & `IFC_FLAG0_MASK;
            `IFC_OFF_FLAG1:    rd_next = flag1_q & `IFC_FLAG1_MASK;
            `IFC_OFF_IRQ_STAT: rd_next = stat_reg;
            `IFC_OFF_IRQ_MASK: rd_next = mask_reg;
            // Unmapped offsets read zero and answer with an error.
            default:           err_next = 1'b1;
        endcase
    end

    // Read data stands for the access cycle only and is zero otherwise, so a stale
    // word can never be mistaken for an answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= {16'h0000, rd_next};
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // The error answer stands in the same access cycle as pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (req.psel && !req.penable) begin
            pslverr <= err_next;
        end else begin
            pslverr <= 1'b0;
        end
    end

endmodule : ifc_flag_regs

// *** ifc_flag_regs_checker.sv ***
// Port-level assertions of the interrupt flag register block.
// Assumes one clock, pclk, and the asynchronous reset presetn.
`timescale 1ns/1ps
`include "ifc_params.svh"
module ifc_flag_regs_checker
    import ifc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sources and outputs
    input wire ifc_trap_t   trap_event,
    input wire logic        interrupt_hold_active,
    input wire logic [15:0] bank0_event,
    input wire logic [15:0] bank1_event,
    input wire logic        alternate_vector_select,
    input wire logic [2:0]  ext_irq_edge_select,
    input wire logic [15:0] irq_flags_bank0,
    input wire logic [15:0] irq_flags_bank1,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] rmask;
    assign rmask = paddr == `IFC_OFF_TRAP ? `IFC_TRAP_MASK :
                   paddr == `IFC_OFF_VEC ? 16'hC007 :
                   paddr == `IFC_OFF_FLAG0 ? `IFC_FLAG0_MASK :
                   paddr == `IFC_OFF_FLAG1 ? `IFC_FLAG1_MASK : `IFC_STAT_MASK;
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_decode: assert property (pready |-> pslverr == (paddr > `IFC_OFF_IRQ_MASK))
        else $error("pslverr does not match decode");
    chk_reserved_zero: assert property (pready && !pwrite |->
        prdata[31:16] == 16'h0000 && (prdata[15:0] & ~rmask) == 16'h0000)
        else $error("reserved bits read nonzero");
    chk_hold_read: assert property ($stable(interrupt_hold_active)[*3] ##0
        (pready && !pwrite && paddr == `IFC_OFF_VEC) |-> prdata[14] == interrupt_hold_active)
        else $error("hold bit wrong");
    chk_vec_follow: assert property (pready && pwrite && paddr == `IFC_OFF_VEC |-> ##2
        alternate_vector_select == $past(pwdata[15], 2)
        && ext_irq_edge_select == $past(pwdata[2:0], 2))
        else $error("vector select outputs wrong");
    chk_flag0_set: assert property (|bank0_event |-> ##2
        (irq_flags_bank0 & $past(bank0_event, 2)) == ($past(bank0_event, 2) & `IFC_FLAG0_MASK))
        else $error("bank0 flag not set");
    chk_flag1_set: assert property (|bank1_event |-> ##2
        (irq_flags_bank1 & $past(bank1_event, 2)) == ($past(bank1_event, 2) & `IFC_FLAG1_MASK))
        else $error("bank1 flag not set");
    chk_unimpl_flags: assert property (!irq_flags_bank0[15] && !irq_flags_bank1[5])
        else $error("unimplemented flag set");
endmodule : ifc_flag_regs_checker

bind ifc_flag_regs ifc_flag_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trap_event, .interrupt_hold_active,
    .bank0_event, .bank1_event, .alternate_vector_select, .ext_irq_edge_select,
    .irq_flags_bank0, .irq_flags_bank1, .irq);

// *** ifc_evt_src.sv ***
// Peripheral and trap event sources facing the flag register block.
// Assumes the bench raises fire for one cycle ahead of each burst.
`timescale 1ns/1ps
module ifc_evt_src
    import ifc_pkg::*;
(
    // Clock, reset and command
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fire,
    input  wire logic [34:0] pat,
    // Event pulses
    output logic      [15:0] bank0_event,
    output logic      [15:0] bank1_event,
    output ifc_trap_t        trap_event
);
    // Pulses last one cycle, so a level-held source cannot hide a lost set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank0_event <= 16'h0000;
            bank1_event <= 16'h0000;
            trap_event  <= ifc_trap_t'(3'b000);
        end else begin
            bank0_event <= fire ? pat[15:0] : 16'h0000;
            bank1_event <= fire ? pat[31:16] : 16'h0000;
            trap_event  <= fire ? ifc_trap_t'(pat[34:32]) : ifc_trap_t'(3'b000);
        end
    end
endmodule : ifc_evt_src

// *** interrupt_flag_control_regs_bench.sv ***
// Self-checking bench of the interrupt flag register block.
// Assumes the event source model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "ifc_params.svh"
module interrupt_flag_control_regs_bench
    import ifc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, fire, er, irq;
    logic        interrupt_hold_active, pready, pslverr, alternate_vector_select;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r1, r2;
    logic [34:0] pat;
    logic [15:0] bank0_event, bank1_event, irq_flags_bank0, irq_flags_bank1;
    logic [2:0]  ext_irq_edge_select;
    ifc_trap_t   trap_event;
    logic [15:0] mdl [6];
    int          n_fail, cmp_count, seed, j;
    localparam logic [15:0] WM [6] = '{`IFC_TRAP_MASK, `IFC_VEC_WR_MASK, `IFC_FLAG0_MASK,
        `IFC_FLAG1_MASK, `IFC_STAT_MASK, `IFC_STAT_MASK};
    ifc_flag_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trap_event, .interrupt_hold_active, .bank0_event, .bank1_event,
        .alternate_vector_select, .ext_irq_edge_select, .irq_flags_bank0, .irq_flags_bank1,
        .irq);
    ifc_evt_src src (.pclk, .presetn, .fire, .pat, .bank0_event, .bank1_event, .trap_event);
    always #25 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input int i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(i * 4);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, i, d);
        if (i == 4) mdl[4] &= ~d[15:0];
        else if (i < 6) mdl[i] = d[15:0] & WM[i];
        chk(32'(er), 32'(i > 5));
    endtask : wr
    task automatic rdc(input int i);
        logic [15:0] e;
        apb(1'b0, i, 32'h0000_0000);
        e = (i == 1) ? (mdl[1] | {1'b0, interrupt_hold_active, 14'h0000}) : mdl[i % 6];
        chk(32'(er), 32'(i > 5));
        if (i < 6) chk(rd, {16'h0000, e});
        else chk(rd, 32'h0000_0000);
        chk(32'(irq), 32'(|(mdl[4] & mdl[5])));
        chk({irq_flags_bank1, irq_flags_bank0}, {mdl[3], mdl[2]});
        chk({28'h000_0000, alternate_vector_select, ext_irq_edge_select},
            {28'h000_0000, mdl[1][15], mdl[1][2:0]});
    endtask : rdc
    task automatic evt(input logic [34:0] p);
        pat <= p;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        mdl[0] |= {12'h000, p[34:32], 1'b0};
        mdl[2] |= p[15:0];
        mdl[3] |= p[31:16];
        mdl[4] |= {13'h0000, |p[31:16], |p[15:0], |p[34:32]};
    endtask : evt
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, fire, interrupt_hold_active} = 7'h00;
        {paddr, pwdata, pat} = '0;
        mdl = '{default: 16'h0000};
        seed = 32'hf553_d20a;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdc(i);
        interrupt_hold_active <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(1);
        interrupt_hold_active <= 1'b0;
        repeat (3) @(posedge pclk);
        wr(5, 32'h0000_0002);
        evt(35'h0_0000_0008);
        rdc(4);
        wr(5, 32'h0000_0000);
        rdc(2);
        wr(4, 32'h0000_0002);
        wr(5, 32'h0000_0007);
        rdc(4);
        for (int k = 0; k < 90; k++) begin
            j = $unsigned($random(seed)) % 7;
            r1 = $random(seed);
            r2 = $random(seed);
            if (k % 3 == 2) evt({r1[2:0], r1 & r2} & 35'h7_FFDF_7FFF);
            else wr(j, r1);
            rdc(j);
        end
        wrap_up();
    end
endmodule : interrupt_flag_control_regs_bench
